//--- ifas_map.svh
`ifndef IFAS_MAP_SVH
`define IFAS_MAP_SVH
// Geometry
`define IFAS_WORD_W 16
`define IFAS_ADDR_W 12
`define IFAS_NUM_PHASES 20
`define IFAS_TOP_SECTOR 3'h7
`define IFAS_TOP1_SECTOR 3'h6
`define IFAS_ADDR_TOP 12'hfff
`define IFAS_REFRESH_END 12'h77f
`define IFAS_RSV_BYTES 12'h02c
// Timing phases
`define IFAS_T1 5'h01
`define IFAS_T4 5'h04
`define IFAS_T5 5'h05
`define IFAS_T7 5'h07
`define IFAS_T9 5'h09
`define IFAS_T10 5'h0a
`define IFAS_T11 5'h0b
`define IFAS_T17 5'h11
`define IFAS_T19 5'h13
// Opcodes
`define IFAS_OP_OPER 5'h00
`define IFAS_OP_IMM 5'h01
`define IFAS_OP_INC1 5'h02
`define IFAS_OP_INC2 5'h03
`define IFAS_OP_DEC1 5'h04
`define IFAS_OP_JMP 5'h05
`define IFAS_OP_TJMP 5'h06
// Auxiliary adder addends
`define IFAS_ADD_ONE 16'h0001
`define IFAS_ADD_TWO 16'h0002
`define IFAS_ADD_FOUR 16'h0004
`define IFAS_ADD_MINUS1 16'hffff
// Indirect chain bit of a fetched word
`define IFAS_CHAIN_BIT 15
// Register map
`define IFAS_PADDR_W 8
`define IFAS_REG_CTRL 8'h00
`define IFAS_REG_STATUS 8'h04
`define IFAS_REG_PC 8'h08
`define IFAS_REG_CURSOR 8'h0c
`define IFAS_REG_OPERAND 8'h10
`define IFAS_PC_RESET 12'h000
`define IFAS_CTRL_RUN_BIT 0
`endif

//--- ifas_pkg.sv
package ifas_pkg;
    // Instruction word fields, bit 15 down to bit 0
    typedef struct packed {
        logic [4:0] opcode;
        logic indirect;
        logic sector_top;
        logic [8:0] disp;
    } ifas_instr_t;
    typedef struct packed {
        logic sign;
        logic zero;
        logic carry;
    } ifas_flags_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [15:0] wdata;
    } ifas_mem_req_t;
    typedef struct packed {
        logic refresh_area;
        logic reserved_area;
        logic indirect;
        ifas_flags_t flags;
        logic exec;
        logic [4:0] phase;
    } ifas_status_t;
    typedef enum logic [2:0] {CLS_OPER, CLS_IMM, CLS_INC, CLS_JMP, CLS_TJMP, CLS_BYTE} ifas_class_t;
    typedef enum logic {CYC_INSTR, CYC_EXEC} ifas_cycle_t;
endpackage

//--- ifas_phase_ctr.sv
`timescale 1ns/100ps
`include "ifas_map.svh"
module ifas_phase_ctr #(
    parameter int NUM_PHASES = `IFAS_NUM_PHASES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic step,
    input wire logic repeat_exec,
    output logic [4:0] phase,
    output ifas_pkg::ifas_cycle_t cycle
);
    localparam logic [4:0] LAST = 5'(NUM_PHASES);

    // Logic uses phases up to T19
    if (NUM_PHASES < 20 || NUM_PHASES > 31) begin : g_bad_phases
        $error("NUM_PHASES out of range");
    end

    ////////////////////////////////////////////////////////////////
    // Phase count, wraps last back to T1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= `IFAS_T1; // RULE_26
        end else if (step) begin
            if (phase == LAST) begin
                phase <= `IFAS_T1; // RULE_13
            end else begin
                phase <= phase + 5'h01;
            end
        end
    end

    // Instruction cycle, then execute cycles until repeat_exec drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle <= ifas_pkg::CYC_INSTR; // RULE_26
        end else if (step && phase == LAST) begin
            case (cycle)
                ifas_pkg::CYC_INSTR: cycle <= ifas_pkg::CYC_EXEC; // RULE_13
                ifas_pkg::CYC_EXEC: cycle <= repeat_exec ? ifas_pkg::CYC_EXEC
                                                          : ifas_pkg::CYC_INSTR;
                default: cycle <= ifas_pkg::CYC_INSTR;
            endcase
        end
    end

    property p_phase_wrap;
        @(posedge pclk) disable iff (!presetn)
        (step && phase == LAST) |=> (phase == `IFAS_T1);
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("phase did not wrap"); // RULE_26
endmodule

//--- ifas_aux_adder.sv
`timescale 1ns/100ps
`include "ifas_map.svh"
module ifas_aux_adder #(
    parameter int W = `IFAS_WORD_W
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    output logic [W-1:0] sum,
    output logic carry,
    output logic zero
);
    // Must cover a full address
    if (W < `IFAS_ADDR_W) begin : g_bad_width
        $error("adder narrower than address");
    end

    // Word add with carry out and zero detect
    assign {carry, sum} = {1'b0, a} + {1'b0, b}; // RULE_24
    assign zero = (sum == '0); // RULE_24
endmodule

//--- ifas_sequencer.sv
// Function
// (RULE_01) Non-memory ops never read operand memory
// (RULE_02) Test jump: second word holds target
// (RULE_03) Opcode 15:11, displacement 8:0, indirect 10
// (RULE_04) Bit 9 selects top or current sector
// (RULE_05) Bit 8 selects lower/upper page
// (RULE_06) 2048 words, eight sectors, two pages
// (RULE_07) Refresh area and top reserved area
// (RULE_08) Bit 9 set: top sector base
// (RULE_09) Current top: next-lower sector base
// (RULE_10) Else program counter sector plus displacement
// (RULE_11) Direct: address used, LSB picks byte
// (RULE_12) Indirect chain while fetched bit 15 set
// (RULE_13) Instruction then execute cycle, 20 phases
// (RULE_14) Fetch phases 1-10, work 11-20
// (RULE_15) Data strobe T4, counter update T19
// (RULE_16) Opcode held after T5
// (RULE_17) Address plus zero, T17 latch, T19
// (RULE_18) Increment at execute T4, T7 latch
// (RULE_19) Execute T9 result back to buffer
// (RULE_20) Counter plus two, T17 latch, T19
// (RULE_21) Increment class: +1, +2, -1
// (RULE_22) Immediate operand from odd byte
// (RULE_23) 12-bit counter, LSB always zero
// (RULE_24) Zero and carry flags from adder
// (RULE_25) Cursor: column low six, line high
// (RULE_26) Phase wraps, reset to instruction T1
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
`include "ifas_map.svh"
module ifas_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`IFAS_PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output ifas_pkg::ifas_mem_req_t mem_req,
    input wire logic [15:0] mem_rdata,
    output ifas_pkg::ifas_flags_t condition_flags,
    output logic [5:0] cursor_line,
    output logic [5:0] cursor_column,
    output logic [7:0] operand
);
    logic run_q;
    logic [11:0] next_instruction_pointer_q;
    logic [11:0] memory_pointer_reg_q;
    logic [15:0] memory_word_buffer_q;
    logic [15:0] auxiliary_result_reg_q;
    logic [11:0] cursor_position_reg_q;
    logic [7:0] operand_q;
    ifas_pkg::ifas_flags_t flags_q;
    ifas_pkg::ifas_instr_t ir_q;
    logic ind_q;
    logic ind_cyc_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [4:0] phase;
    ifas_pkg::ifas_cycle_t cycle;
    ifas_pkg::ifas_class_t cls;
    ifas_pkg::ifas_status_t status;
    logic step;
    logic exec;
    logic memref;
    logic needs_mem;
    logic inc_work;
    logic tjmp_taken;
    logic [2:0] sec_sel;
    logic [11:0] ea_calc;
    logic [11:0] pc_target;
    logic [15:0] add_a;
    logic [15:0] add_b;
    logic [15:0] inc_step;
    logic [15:0] add_sum;
    logic add_carry;
    logic add_zero;
    logic apb_wr;
    logic apb_setup;

    assign step = run_q;
    assign exec = (cycle == ifas_pkg::CYC_EXEC);

    ////////////////////////////////////////////////////////////////
    // Phase sequencing and auxiliary adder
    ifas_phase_ctr #(.NUM_PHASES(`IFAS_NUM_PHASES)) u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .step(step),
        .repeat_exec(ind_cyc_q), // RULE_12
        .phase(phase),
        .cycle(cycle)
    );

    ifas_aux_adder #(.W(`IFAS_WORD_W)) u_auxiliary_adder (
        .a(add_a),
        .b(add_b),
        .sum(add_sum),
        .carry(add_carry),
        .zero(add_zero)
    );

    ////////////////////////////////////////////////////////////////
    // Opcode class decode
    always_comb begin
        case (ir_q.opcode)
            `IFAS_OP_OPER: cls = ifas_pkg::CLS_OPER;
            `IFAS_OP_IMM: cls = ifas_pkg::CLS_IMM;
            `IFAS_OP_INC1,
            `IFAS_OP_INC2,
            `IFAS_OP_DEC1: cls = ifas_pkg::CLS_INC;
            `IFAS_OP_JMP: cls = ifas_pkg::CLS_JMP;
            `IFAS_OP_TJMP: cls = ifas_pkg::CLS_TJMP;
            default: cls = ifas_pkg::CLS_BYTE;
        endcase
    end

    // Increment class addend
    always_comb begin
        case (ir_q.opcode)
            `IFAS_OP_INC2: inc_step = `IFAS_ADD_TWO; // RULE_21
            `IFAS_OP_DEC1: inc_step = `IFAS_ADD_MINUS1; // RULE_21
            default: inc_step = `IFAS_ADD_ONE; // RULE_21
        endcase
    end

    assign memref = (cls == ifas_pkg::CLS_BYTE) || (cls == ifas_pkg::CLS_INC)
                    || (cls == ifas_pkg::CLS_JMP);
    // Memory read needed in this cycle's fetch half
    assign needs_mem = !exec || ind_cyc_q || (cls == ifas_pkg::CLS_BYTE) // RULE_01
                       || (cls == ifas_pkg::CLS_INC) || (cls == ifas_pkg::CLS_TJMP); // RULE_14
    assign inc_work = exec && !ind_cyc_q && (cls == ifas_pkg::CLS_INC);

    ////////////////////////////////////////////////////////////////
    // Sector-relative effective address
    always_comb begin
        if (ir_q.sector_top) begin
            sec_sel = `IFAS_TOP_SECTOR; // RULE_08
        end else if (next_instruction_pointer_q[11:9] == `IFAS_TOP_SECTOR) begin
            sec_sel = `IFAS_TOP1_SECTOR; // RULE_09
        end else begin
            sec_sel = next_instruction_pointer_q[11:9]; // RULE_10
        end
    end
    // Sector from bits 11:9, page bit 8 rides in the displacement
    assign ea_calc = {sec_sel, ir_q.disp}; // RULE_04 RULE_05 RULE_06

    // Adder operand steering by cycle and phase
    always_comb begin
        add_a = '0;
        add_b = '0;
        if (inc_work && phase >= `IFAS_T4 && phase < `IFAS_T11) begin
            add_a = memory_word_buffer_q; // RULE_18
            add_b = inc_step;
        end else if (exec) begin
            add_a = {4'h0, next_instruction_pointer_q}; // RULE_20
            add_b = (cls == ifas_pkg::CLS_TJMP) ? `IFAS_ADD_FOUR : `IFAS_ADD_TWO; // RULE_02
        end else if (cls == ifas_pkg::CLS_TJMP) begin
            add_a = {4'h0, next_instruction_pointer_q}; // RULE_02
            add_b = `IFAS_ADD_TWO;
        end else begin
            add_a = {4'h0, ea_calc}; // RULE_17
        end
    end

    ////////////////////////////////////////////////////////////////
    // Memory request strobes
    assign mem_req.rd = step && phase == `IFAS_T1 && needs_mem; // RULE_01
    assign mem_req.wr = step && phase == `IFAS_T10 && inc_work; // RULE_19
    assign mem_req.addr = memory_pointer_reg_q;
    assign mem_req.wdata = memory_word_buffer_q;

    // Data buffer: strobe at T4, write-back load at T9
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            memory_word_buffer_q <= '0;
        end else if (step) begin
            if (phase == `IFAS_T4 && needs_mem) begin
                memory_word_buffer_q <= mem_rdata; // RULE_15
            end else if (phase == `IFAS_T9 && inc_work) begin
                memory_word_buffer_q <= auxiliary_result_reg_q; // RULE_19
            end
        end
    end

    // Opcode and address fields captured at end of T5
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_q <= '0;
        end else if (step && !exec && phase == `IFAS_T5) begin
            ir_q <= ifas_pkg::ifas_instr_t'(memory_word_buffer_q); // RULE_16 RULE_03
        end
    end

    // Auxiliary result latch and condition flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auxiliary_result_reg_q <= '0;
        end else if (step && phase == `IFAS_T17) begin
            auxiliary_result_reg_q <= add_sum; // RULE_17 RULE_20
        end else if (step && phase == `IFAS_T7 && inc_work) begin
            auxiliary_result_reg_q <= add_sum; // RULE_18
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
        end else if (step && phase == `IFAS_T7 && inc_work) begin
            flags_q.zero <= add_zero; // RULE_24
            flags_q.carry <= add_carry; // RULE_24
            flags_q.sign <= add_sum[15];
        end else if (step && phase == `IFAS_T11 && (exec ? (!ind_cyc_q
                     && cls == ifas_pkg::CLS_BYTE) : (cls == ifas_pkg::CLS_IMM))) begin
            flags_q.zero <= (operand_q == 8'h00);
            flags_q.sign <= operand_q[7];
        end
    end

    // Byte operand: immediate odd byte or addressed byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operand_q <= '0;
        end else if (step && phase == `IFAS_T5 && !exec
                     && memory_word_buffer_q[15:11] == `IFAS_OP_IMM) begin
            operand_q <= memory_word_buffer_q[7:0]; // RULE_22
        end else if (step && phase == `IFAS_T5 && exec && !ind_cyc_q
                     && cls == ifas_pkg::CLS_BYTE) begin
            operand_q <= memory_pointer_reg_q[0] ? memory_word_buffer_q[7:0]
                                                 : memory_word_buffer_q[15:8]; // RULE_11
        end
    end

    // Indirection pending and indirect-cycle marker
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind_q <= 1'b0;
        end else if (step && phase == `IFAS_T19) begin
            if (!exec) begin
                ind_q <= memref && ir_q.indirect; // RULE_11 RULE_12
            end else if (ind_cyc_q) begin
                ind_q <= memory_word_buffer_q[`IFAS_CHAIN_BIT]; // RULE_12
            end else begin
                ind_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind_cyc_q <= 1'b0;
        end else if (step && phase == 5'(`IFAS_NUM_PHASES)) begin
            ind_cyc_q <= ind_q; // RULE_12
        end
    end

    ////////////////////////////////////////////////////////////////
    // Next program counter, always even
    assign tjmp_taken = (cls == ifas_pkg::CLS_TJMP) && flags_q.zero;
    always_comb begin
        if (cls == ifas_pkg::CLS_JMP) begin
            pc_target = memory_pointer_reg_q;
        end else if (tjmp_taken) begin
            pc_target = memory_word_buffer_q[11:0]; // RULE_02
        end else begin
            pc_target = auxiliary_result_reg_q[11:0]; // RULE_20
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_instruction_pointer_q <= `IFAS_PC_RESET;
        end else if (apb_wr && paddr == `IFAS_REG_PC) begin
            next_instruction_pointer_q <= {pwdata[11:1], 1'b0}; // RULE_23
        end else if (step && exec && !ind_cyc_q && phase == `IFAS_T19) begin
            next_instruction_pointer_q <= {pc_target[11:1], 1'b0}; // RULE_15 RULE_23
        end
    end

    // Address register loads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            memory_pointer_reg_q <= `IFAS_PC_RESET;
        end else if (apb_wr && paddr == `IFAS_REG_PC) begin
            memory_pointer_reg_q <= {pwdata[11:1], 1'b0};
        end else if (step && phase == `IFAS_T19) begin
            if (!exec) begin
                if (memref || cls == ifas_pkg::CLS_TJMP) begin
                    memory_pointer_reg_q <= auxiliary_result_reg_q[11:0]; // RULE_17
                end
            end else if (ind_cyc_q) begin
                memory_pointer_reg_q <= memory_word_buffer_q[11:0]; // RULE_12
            end else begin
                memory_pointer_reg_q <= {pc_target[11:1], 1'b0}; // RULE_20
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // APB slave, zero wait, read data captured in setup
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite;
    assign pready = psel && penable;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

    always_comb begin
        status.refresh_area = (memory_pointer_reg_q <= `IFAS_REFRESH_END); // RULE_07
        status.reserved_area = (memory_pointer_reg_q >
                                (`IFAS_ADDR_TOP - `IFAS_RSV_BYTES)); // RULE_07
        status.indirect = ind_q;
        status.flags = flags_q;
        status.exec = exec;
        status.phase = phase;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
            cursor_position_reg_q <= '0;
        end else if (apb_wr) begin
            case (paddr)
                `IFAS_REG_CTRL: run_q <= pwdata[`IFAS_CTRL_RUN_BIT];
                `IFAS_REG_CURSOR: cursor_position_reg_q <= pwdata[11:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (apb_setup) begin
            pslverr_q <= 1'b0;
            case (paddr)
                `IFAS_REG_CTRL: prdata_q <= {31'h0, run_q};
                `IFAS_REG_STATUS: prdata_q <= {20'h0, status};
                `IFAS_REG_PC: prdata_q <= {20'h0, next_instruction_pointer_q};
                `IFAS_REG_CURSOR: prdata_q <= {20'h0, cursor_position_reg_q};
                `IFAS_REG_OPERAND: prdata_q <= {8'h0, ir_q, operand_q};
                default: begin
                    prdata_q <= '0;
                    pslverr_q <= 1'b1;
                end
            endcase
        end
    end

    // Cursor fields and flag outputs
    assign cursor_line = cursor_position_reg_q[11:6]; // RULE_25
    assign cursor_column = cursor_position_reg_q[5:0]; // RULE_25
    assign condition_flags = flags_q;
    assign operand = operand_q;

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_no_operand_read;
        (exec && !ind_cyc_q && (cls == ifas_pkg::CLS_OPER || cls == ifas_pkg::CLS_IMM))
        |-> !mem_req.rd;
    endproperty
    a_no_operand_read: assert property (p_no_operand_read) else $error("operand read"); // RULE_01

    property p_t4_strobe;
        (step && phase == `IFAS_T4 && needs_mem) |=> (memory_word_buffer_q == $past(mem_rdata));
    endproperty
    a_t4_strobe: assert property (p_t4_strobe) else $error("buffer missed T4 strobe"); // RULE_15

    property p_ir_hold;
        (!exec && phase > `IFAS_T5) || exec |=> $stable(ir_q);
    endproperty
    a_ir_hold: assert property (p_ir_hold) else $error("opcode changed late"); // RULE_16

    property p_pc_even;
        next_instruction_pointer_q[0] == 1'b0;
    endproperty
    a_pc_even: assert property (p_pc_even) else $error("counter LSB set"); // RULE_23

    property p_pc_at_t19;
        $changed(next_instruction_pointer_q) && !$past(apb_wr) |-> $past(phase) == `IFAS_T19;
    endproperty
    a_pc_at_t19: assert property (p_pc_at_t19) else $error("counter moved off T19"); // RULE_15

    property p_writeback;
        (step && phase == `IFAS_T9 && inc_work) |=> (memory_word_buffer_q ==
            $past(auxiliary_result_reg_q)) && mem_req.wr;
    endproperty
    a_writeback: assert property (p_writeback) else $error("write-back lost"); // RULE_19

    property p_top_sector;
        (step && !exec && phase == `IFAS_T17 && memref && ir_q.sector_top)
        |=> auxiliary_result_reg_q[11:9] == `IFAS_TOP_SECTOR ##2
            memory_pointer_reg_q[11:9] == `IFAS_TOP_SECTOR;
    endproperty
    a_top_sector: assert property (p_top_sector) else $error("top sector not used"); // RULE_08

    property p_pc_plus_two;
        (step && exec && !ind_cyc_q && phase == `IFAS_T17 && cls != ifas_pkg::CLS_TJMP)
        |=> auxiliary_result_reg_q[11:0] == $past(next_instruction_pointer_q) + 12'h002;
    endproperty
    a_pc_plus_two: assert property (p_pc_plus_two) else $error("counter step wrong"); // RULE_20
endmodule

//--- ifas_mem_model.sv
`timescale 1ns/100ps
module ifas_mem_model (
    input wire logic pclk,
    input wire ifas_pkg::ifas_mem_req_t mem_req,
    output logic [15:0] mem_rdata
);
    logic [15:0] mem_q [0:2047];
    logic [15:0] last_q = 16'h0000;
    logic [1:0] hold_q = 2'h0;
    ////////////////////////////////////////////////////////////////////////////////
    // Word read held three cycles, writes by word index
    always @(posedge pclk) begin
        if (mem_req.rd === 1'b1) begin
            last_q <= mem_q[mem_req.addr[11:1]];
            hold_q <= 2'h3;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end
        if (mem_req.wr === 1'b1) begin
            mem_q[mem_req.addr[11:1]] <= mem_req.wdata;
        end
    end
    // Stale data inverted once the hold has run out
    assign mem_rdata = (hold_q != 2'h0) ? last_q : ~last_q;
endmodule

//--- testbench.sv
`timescale 1ns/100ps
module testbench;
    typedef struct {
        logic [11:0] pc;
        logic [15:0] instr;
        logic [11:0] a1;
        int gap;
        logic [11:0] ea;
        logic [15:0] din;
        logic [15:0] dout;
        logic [2:0] fl;
    } ifas_row_t;
    ifas_row_t rows [9] = '{
        '{12'h800, 16'h1020, 12'h820, 20, 12'h820, 16'h00ff, 16'h0100, 3'h0},
        '{12'h800, 16'h1820, 12'h820, 20, 12'h820, 16'h7ffe, 16'h8000, 3'h4},
        '{12'h800, 16'h2020, 12'h820, 20, 12'h820, 16'h0000, 16'hffff, 3'h4},
        '{12'h800, 16'h1230, 12'he30, 20, 12'he30, 16'h0010, 16'h0011, 3'h0},
        '{12'he00, 16'h1140, 12'hd40, 20, 12'hd40, 16'hffff, 16'h0000, 3'h3},
        '{12'h800, 16'h1460, 12'h860, 20, 12'h900, 16'h1234, 16'h1235, 3'h0},
        '{12'h800, 16'h085a, 12'h802, 40, 12'h85a, 16'h1111, 16'h1111, 3'h0},
        '{12'h800, 16'h3000, 12'h802, 20, 12'h804, 16'h2804, 16'h2804, 3'h0},
        '{12'h800, 16'h3821, 12'h821, 20, 12'h821, 16'h12c4, 16'h12c4, 3'h4}};
    logic [11:0] pvs [4] = '{12'h77e, 12'h780, 12'hfd2, 12'hfd4};
    logic [1:0] pex [4] = '{2'h2, 2'h0, 2'h0, 2'h1};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ifas_pkg::ifas_mem_req_t mem_req;
    logic [15:0] mem_rdata;
    ifas_pkg::ifas_flags_t flags;
    logic [5:0] cur_line;
    logic [5:0] cur_col;
    logic [7:0] operand;
    logic [31:0] rd_data;
    logic rd_err;
    logic [15:0] jw;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int rd_t [$];
    logic [11:0] rd_a [$];

    always #25 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    // Log every memory read with its cycle
    always @(posedge pclk) begin
        if (mem_req.rd === 1'b1) begin
            rd_t.push_back(cyc);
            rd_a.push_back(mem_req.addr);
        end
    end

    ifas_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem_rdata),
        .condition_flags(flags), .cursor_line(cur_line), .cursor_column(cur_col),
        .operand(operand));
    ifas_mem_model mem_u (.pclk(pclk), .mem_req(mem_req), .mem_rdata(mem_rdata));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        tally_and_finish();
    end

    // Instruction rows, then register cases
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            do_reset();
            jw = 16'h2800 | ((rows[i].pc[11:9] == 3'h7) ? 16'h0200 : 16'h0000);
            jw[8:0] = rows[i].pc[8:0] + 9'h002;
            mem_u.mem_q[rows[i].ea[11:1]] = rows[i].din;
            mem_u.mem_q[11'h430] = 16'h8870;
            mem_u.mem_q[11'h438] = 16'h0900;
            mem_u.mem_q[rows[i].pc[11:1]] = rows[i].instr;
            mem_u.mem_q[rows[i].pc[11:1] + 11'h1] = jw;
            apb(1'b1, 8'h08, {20'h0, rows[i].pc});
            rd_t.delete();
            rd_a.delete();
            apb(1'b1, 8'h00, 32'h1);
            repeat (200) @(posedge pclk);
            chk("fetch_addr", rd_a[0], rows[i].pc);
            chk("second_addr", rd_a[1], rows[i].a1);
            chk("read_gap", rd_t[1] - rd_t[0], rows[i].gap);
            chk("mem_word", mem_u.mem_q[rows[i].ea[11:1]], rows[i].dout);
            if (rows[i].instr[15:11] == 5'h01) begin
                chk("operand", operand, rows[i].instr[7:0]);
            end else if (rows[i].instr[15:11] == 5'h07) begin
                jw = rows[i].din;
                chk("byte", operand, rows[i].ea[0] ? jw[7:0] : jw[15:8]);
            end
            chk("flags", flags, rows[i].fl);
            $display("row %0d done", i);
        end
        do_reset();
        apb(1'b0, 8'h04, 32'h0);
        chk("status", rd_data, 32'h801);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped_err", {31'h0, rd_err}, 32'h1);
        chk("unmapped_data", rd_data, 32'h0);
        apb(1'b1, 8'h08, 32'h123);
        apb(1'b0, 8'h08, 32'h0);
        chk("pc_odd", rd_data, 32'h122);
        apb(1'b1, 8'h08, 32'hffffffff);
        apb(1'b0, 8'h08, 32'h0);
        chk("pc_width", rd_data, 32'hffe);
        foreach (pvs[i]) begin
            apb(1'b1, 8'h08, {20'h0, pvs[i]});
            apb(1'b0, 8'h04, 32'h0);
            chk("area_bits", rd_data[11:10], pex[i]);
        end
        apb(1'b1, 8'h0c, 32'habc);
        apb(1'b0, 8'h0c, 32'h0);
        chk("cursor", rd_data, 32'habc);
        chk("line", cur_line, 6'h2a);
        chk("column", cur_col, 6'h3c);
        $display("register tests done");
        tally_and_finish();
    end
endmodule
